/* File: bench/sram_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sram_model
(
  input  wire logic        ref_clk,
  input  wire logic        mux_mode,
  input  wire logic [15:0] ext_addr,
  input  wire logic [7:0]  ext_data_out,
  input  wire logic        ext_rd_n,
  input  wire logic        ext_wr_n,
  input  wire logic        ext_ale,
  input  wire logic        ext_data_oe_n,
  output logic [7:0]       ext_data_in
);
  logic [7:0] mem [256];
  logic [7:0] bus_val;
  logic [7:0] lat_reg;
  logic [7:0] last_reg;
  logic [7:0] a;

  initial last_reg = 8'h00;
  // undriven shared pins read as the inverse, so a missing drive corrupts data
  assign bus_val = ext_data_oe_n ? ~ext_data_out : ext_data_out;
  // transparent while ale high, so the value at its fall is kept
  always @(posedge ref_clk)
    if (ext_ale)
      lat_reg <= bus_val;
  assign a = mux_mode ? lat_reg : ext_addr[7:0];
  always @(posedge ref_clk)
  begin
    if (!ext_wr_n)
      mem[a] <= bus_val;
    if (!ext_rd_n)
      last_reg <= mem[a];
  end
  // released bus shows the inverse, so a stale sample cannot match
  assign ext_data_in = !ext_rd_n ? mem[a] : ~last_reg;
endmodule : sram_model
`default_nettype wire

/* File: bench/xdata_if_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module xdata_if_tb
  import xdata_pkg::*;
;
  typedef struct packed {
    logic [7:0]  cfg, page;
    logic        wide, wr, isel;
    logic [15:0] dp;
    logic [7:0]  idx, wd;
    logic        off;
    logic [15:0] ea;
    logic        hi;
    logic [7:0]  rd;
  } row_s;

  logic        ref_clk, rst, reg_wr, reg_rd, move_start, move_busy, move_done;
  logic        ext_addr_hi_oe_n, ext_addr_lo_oe_n, ext_data_oe_n, ext_rd_n, ext_wr_n, ext_ale, hi_seen, lo_seen;
  logic        doe_seen;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, move_rdata, first_index_register, second_index_register;
  logic [7:0]  ext_data_out, ext_data_in, cfg_v, tim_v;
  logic [15:0] data_pointer, ext_addr, addr_seen;
  move_req_s   move_req;
  int          n_mismatch, cmp_count, scnt, bcnt, acnt, both;
  row_s        rows [11];

  xdata_if uut (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .move_start, .move_req,
    .data_pointer, .first_index_register, .second_index_register, .move_busy, .move_done, .move_rdata,
    .ext_addr, .ext_addr_hi_oe_n, .ext_addr_lo_oe_n, .ext_data_out, .ext_data_oe_n, .ext_data_in,
    .ext_rd_n, .ext_wr_n, .ext_ale);
  sram_model far (.ref_clk, .mux_mode(~cfg_v[4]), .ext_addr, .ext_data_out, .ext_rd_n, .ext_wr_n,
    .ext_ale, .ext_data_oe_n, .ext_data_in);

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // sampled mid-cycle, clear of the edge that launches the outputs
  always @(negedge ref_clk)
  begin
    if (move_busy === 1'b1)
      bcnt++;
    if (ext_rd_n === 1'b0 || ext_wr_n === 1'b0)
    begin
      scnt++;
      addr_seen = ext_addr;
      hi_seen = ext_addr_hi_oe_n;
      lo_seen = ext_addr_lo_oe_n;
      doe_seen = ext_data_oe_n;
    end
    if (ext_rd_n === 1'b0 && ext_wr_n === 1'b0)
      both++;
    if (ext_ale === 1'b1)
      acnt++;
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic end_sim;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wreg

  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", 16'(reg_rdata), 16'(e));
  endtask : rreg

  task automatic cfgset(input logic [7:0] c, input logic [7:0] t);
    wreg(CONFIG_OFS, c);
    wreg(TIMING_OFS, t);
    cfg_v = c;
    tim_v = t;
  endtask : cfgset

  task automatic mv(input logic wide, wr, isel, input logic [15:0] dp, input logic [7:0] idx, wd,
                    input logic off, input logic [15:0] ea, input logic hi, input logic [7:0] rd);
    int   eb;
    logic done;
    eb = off ? int'(tim_v[7:6]) + int'(tim_v[5:2]) + int'(tim_v[1:0]) + 5 : 1;
    if (off && !cfg_v[4])
      eb = eb + 2 * (int'(cfg_v[1:0]) + 1);
    @(posedge ref_clk);
    {scnt, bcnt, acnt, both} = '0;
    move_start <= 1'b1;
    move_req <= '{wide, wr, isel, wd};
    data_pointer <= dp;
    // the unselected index holds the complement, exposing a wrong pick
    first_index_register <= isel ? ~idx : idx;
    second_index_register <= isel ? idx : ~idx;
    @(posedge ref_clk);
    move_start <= 1'b0;
    done = 1'b0;
    for (int i = 0; i < 100 && !done; i++)
    begin
      @(posedge ref_clk);
      #1 done = (move_done === 1'b1);
    end
    chk("done", 16'(done), 16'h0001);
    chk("offchip", 16'(scnt != 0), 16'(off));
    chk("busy", 16'(bcnt), 16'(eb));
    chk("both", 16'(both), 16'h0000);
    chk("ale", 16'(acnt), 16'((off && !cfg_v[4]) ? int'(cfg_v[1:0]) + 1 : 0));
    if (off)
    begin
      chk("strobe", 16'(scnt), 16'(int'(tim_v[5:2]) + 1));
      chk("hi_oe_n", 16'(hi_seen), 16'(!hi));
      chk("lo_oe_n", 16'(lo_seen), 16'h0000);
      chk("data_oe_n", 16'(doe_seen), 16'(!wr));
      if (cfg_v[4])
        chk("addr", addr_seen & (hi ? 16'hffff : 16'h00ff), ea);
    end
    if (!wr)
      chk("rdata", 16'(move_rdata), 16'(rd));
  endtask : mv

  initial
  begin
    rst = 1'b1;
    {reg_wr, reg_rd, move_start} = '0;
    {reg_addr, reg_wdata, first_index_register, second_index_register, data_pointer} = '0;
    move_req = '0;
    {cfg_v, tim_v} = '0;
    rows = '{
      '{8'h10, 8'h00, 1, 1, 0, 16'h1005, 8'h00, 8'h5a, 0, 16'h0000, 0, 8'h00},
      '{8'h10, 8'h00, 1, 0, 0, 16'h2005, 8'h00, 8'h00, 0, 16'h0000, 0, 8'h5a},
      '{8'h10, 8'h30, 0, 0, 1, 16'h0000, 8'h05, 8'h00, 0, 16'h0000, 0, 8'h5a},
      '{8'h14, 8'h00, 1, 1, 0, 16'h1234, 8'h00, 8'hc3, 1, 16'h1234, 1, 8'h00},
      '{8'h14, 8'h00, 1, 0, 0, 16'h0005, 8'h00, 8'h00, 0, 16'h0000, 0, 8'h5a},
      '{8'h14, 8'h20, 0, 1, 1, 16'h0000, 8'h34, 8'h77, 1, 16'h0034, 0, 8'h00},
      '{8'h18, 8'h12, 0, 0, 0, 16'h0000, 8'h34, 8'h00, 1, 16'h1234, 1, 8'h77},
      '{8'h18, 8'h00, 0, 0, 0, 16'h0000, 8'h05, 8'h00, 0, 16'h0000, 0, 8'h5a},
      '{8'h1c, 8'h00, 1, 0, 0, 16'h0034, 8'h00, 8'h00, 1, 16'h0034, 1, 8'h77},
      '{8'h1c, 8'h00, 0, 1, 0, 16'h0000, 8'h05, 8'h99, 1, 16'h0005, 0, 8'h00},
      '{8'h10, 8'h00, 1, 0, 0, 16'h0005, 8'h00, 8'h00, 0, 16'h0000, 0, 8'h5a}};
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    rreg(TIMING_OFS, TIMING_RESET);
    rreg(CONFIG_OFS, 8'h00);
    rreg(PAGE_OFS, 8'h00);
    rreg(8'h55, 8'h00);
    wreg(CONFIG_OFS, 8'h1c);
    cfg_v = 8'h1c;
    tim_v = 8'hff;
    mv(1, 1, 0, 16'h0010, 8'h00, 8'hab, 1, 16'h0010, 1, 8'h00);
    cfgset(8'h1c, 8'h00);
    mv(1, 1, 0, 16'h0011, 8'h00, 8'hac, 1, 16'h0011, 1, 8'h00);
    foreach (rows[i])
    begin
      cfgset(rows[i].cfg, 8'h4d);
      wreg(PAGE_OFS, rows[i].page);
      mv(rows[i].wide, rows[i].wr, rows[i].isel, rows[i].dp, rows[i].idx, rows[i].wd,
         rows[i].off, rows[i].ea, rows[i].hi, rows[i].rd);
    end
    cfgset(8'h0f, 8'h4d);
    mv(1, 1, 0, 16'h00a7, 8'h00, 8'h3c, 1, 16'h00a7, 1, 8'h00);
    cfgset(8'h0c, 8'h0c);
    mv(1, 0, 0, 16'h00a7, 8'h00, 8'h00, 1, 16'h00a7, 1, 8'h3c);
    // config bits 7:5 read back as zero
    wreg(CONFIG_OFS, 8'hff);
    rreg(CONFIG_OFS, 8'h1f);
    wreg(PAGE_OFS, 8'h5c);
    // reset in mid-run brings every register back
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rreg(TIMING_OFS, TIMING_RESET);
    rreg(CONFIG_OFS, CONFIG_RESET);
    rreg(PAGE_OFS, PAGE_RESET);
    end_sim;
  end

  initial
  begin
    #200000;
    n_mismatch++;
    end_sim;
  end
endmodule : xdata_if_tb
`default_nettype wire

/* File: core/xdata_if.sv */
// Function
// - mode 00 keeps every move on-chip
// - internal mode wraps addresses modulo 4 kB
// - short move: page high, index low
// - wide move uses the data pointer
// - split modes: low on-chip, high off-chip
// - split no-bank short move drives A[7:0] only
// - split wide move drives all sixteen lines
// - bank mode uses page for routing
// - bank mode short move drives all lines
// - mode 11 sends every move off-chip
// - external short move: page ignored, low only
// - external wide move drives all lines
// - non-mux mode: separate pins, no latch
// - setup cycles from timing bits 7:6
// - strobe low width field plus one
// - hold cycles from timing bits 1:0
// - timing register resets to all ones
// - off-chip move takes fields plus five
// - mux mode adds latch pulse, minimum seven
// - mux select bit 0 multiplexed, 1 separate
// - latch high and low 1 to 4 cycles
// - low address on shared pins while latch high
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module xdata_if
  import xdata_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  input  wire logic        move_start,
  input  wire move_req_s   move_req,
  input  wire logic [15:0] data_pointer,
  input  wire logic [7:0]  first_index_register,
  input  wire logic [7:0]  second_index_register,
  output logic             move_busy,
  output logic             move_done,
  output logic [7:0]       move_rdata,
  output logic [15:0]      ext_addr,
  output logic             ext_addr_hi_oe_n,
  output logic             ext_addr_lo_oe_n,
  output logic [7:0]       ext_data_out,
  output logic             ext_data_oe_n,
  input  wire logic [7:0]  ext_data_in,
  output logic             ext_rd_n,
  output logic             ext_wr_n,
  output logic             ext_ale
);

  typedef enum logic [6:0] {
    ST_IDLE  = 7'b0000001,
    ST_ALEH  = 7'b0000010,
    ST_ALEL  = 7'b0000100,
    ST_SETUP = 7'b0001000,
    ST_STRB  = 7'b0010000,
    ST_HOLD  = 7'b0100000,
    ST_TAIL  = 7'b1000000
  } bus_state_e;

  logic [7:0]  timing_reg;
  logic [7:0]  config_reg;
  logic [7:0]  page_high_byte_register;
  logic [7:0]  ram [0:(1<<RAM_AW)-1];
  logic [7:0]  ram_q;
  logic        ram_rd_pend;
  bus_state_e  state_reg;
  logic [3:0]  cnt_reg;
  logic        wr_reg;
  logic [7:0]  wdata_reg;
  logic [15:0] eff_addr;
  logic        off_chip;
  logic        drive_upper;
  logic [7:0]  din_s1, din_s2, din_s3;

  wire logic [1:0] memory_mode_field    = config_reg[MODE_LSB +: 2];
  wire logic       bus_mux_select_bit   = config_reg[MUX_BIT];
  wire logic [1:0] latch_width_field    = config_reg[LATCH_LSB +: 2];
  wire logic [1:0] addr_setup_field     = timing_reg[SETUP_LSB +: 2];
  wire logic [3:0] strobe_width_field   = timing_reg[WIDTH_LSB +: 4];
  wire logic [1:0] addr_hold_field      = timing_reg[HOLD_LSB +: 2];
  // an on-chip read may still be pending in idle, so busy gates the start
  wire logic       start_off            = move_start && !move_busy && off_chip;

  function automatic logic above_ram(input logic [15:0] a);
    above_ram = (a[15:RAM_AW] != '0);
  endfunction : above_ram

  // effective address and routing
  always_comb
  begin
    if (move_req.wide)
      eff_addr = data_pointer;
    else
      eff_addr = {page_high_byte_register,
                  move_req.index_sel ? second_index_register : first_index_register};
    unique case (memory_mode_field)
      MODE_INTERNAL: off_chip = 1'b0;
      MODE_SPLIT,
      MODE_BANK:     off_chip = above_ram(eff_addr);
      default:       off_chip = 1'b1;
    endcase
    // short moves drive upper lines only in bank mode
    drive_upper = move_req.wide || (memory_mode_field == MODE_BANK);
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      timing_reg              <= TIMING_RESET;
      config_reg              <= CONFIG_RESET;
      page_high_byte_register <= PAGE_RESET;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        TIMING_OFS: timing_reg              <= reg_wdata;
        CONFIG_OFS: config_reg              <= {3'h0, reg_wdata[4:0]};
        PAGE_OFS:   page_high_byte_register <= reg_wdata;
        default:    ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        TIMING_OFS: reg_rdata <= timing_reg;
        CONFIG_OFS: reg_rdata <= config_reg;
        PAGE_OFS:   reg_rdata <= page_high_byte_register;
        default:    reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

  // pin sampler for the data bus
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      din_s1 <= 8'h00;
      din_s2 <= 8'h00;
      din_s3 <= 8'h00;
    end
    else
    begin
      din_s1 <= ext_data_in;
      din_s2 <= din_s1;
      din_s3 <= din_s2;
    end
  end

  // on-chip ram, aliased modulo 4 kB in every mode that reaches it
  always_ff @(posedge ref_clk)
  begin
    if (move_start && !move_busy && !off_chip)
    begin
      if (move_req.write)
        ram[eff_addr[RAM_AW-1:0]] <= move_req.wdata;
      ram_q <= ram[eff_addr[RAM_AW-1:0]];
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      ram_rd_pend <= 1'b0;
    else
      ram_rd_pend <= move_start && !move_busy && !off_chip;
  end

  // off-chip sequencer
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg        <= ST_IDLE;
      cnt_reg          <= 4'h0;
      wr_reg           <= 1'b0;
      wdata_reg        <= 8'h00;
      ext_addr         <= 16'h0000;
      ext_addr_hi_oe_n <= 1'b1;
      ext_addr_lo_oe_n <= 1'b1;
    end
    else
    begin
      unique case (state_reg)
        ST_IDLE:
          if (start_off)
          begin
            wr_reg           <= move_req.write;
            wdata_reg        <= move_req.wdata;
            ext_addr         <= eff_addr;
            ext_addr_hi_oe_n <= !drive_upper;
            ext_addr_lo_oe_n <= 1'b0;
            if (!bus_mux_select_bit)
            begin
              state_reg <= ST_ALEH;
              cnt_reg   <= {2'h0, latch_width_field};
            end
            else
            begin
              state_reg <= ST_SETUP;
              cnt_reg   <= {2'h0, addr_setup_field};
            end
          end
        ST_ALEH:
          if (cnt_reg == 4'h0)
          begin
            state_reg <= ST_ALEL;
            cnt_reg   <= {2'h0, latch_width_field};
          end
          else
            cnt_reg <= cnt_reg - 4'h1;
        ST_ALEL:
          if (cnt_reg == 4'h0)
          begin
            state_reg <= ST_SETUP;
            cnt_reg   <= {2'h0, addr_setup_field};
          end
          else
            cnt_reg <= cnt_reg - 4'h1;
        ST_SETUP:
          if (cnt_reg == 4'h0)
          begin
            state_reg <= ST_STRB;
            cnt_reg   <= strobe_width_field;
          end
          else
            cnt_reg <= cnt_reg - 4'h1;
        ST_STRB:
          if (cnt_reg == 4'h0)
          begin
            state_reg <= ST_HOLD;
            cnt_reg   <= {2'h0, addr_hold_field};
          end
          else
            cnt_reg <= cnt_reg - 4'h1;
        ST_HOLD:
          if (cnt_reg == 4'h0)
          begin
            state_reg        <= ST_TAIL;
            cnt_reg          <= {2'h0, FIXED_CYCLES};
            ext_addr_hi_oe_n <= 1'b1;
            ext_addr_lo_oe_n <= 1'b1;
          end
          else
            cnt_reg <= cnt_reg - 4'h1;
        ST_TAIL:
          // setup, strobe and hold each add one implicit cycle, tail makes up the rest of the five
          if (cnt_reg == 4'h1)
            state_reg <= ST_IDLE;
          else
            cnt_reg <= cnt_reg - 4'h1;
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // pin and result outputs from flip-flops
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ext_rd_n      <= 1'b1;
      ext_wr_n      <= 1'b1;
      ext_ale       <= 1'b0;
      ext_data_out  <= 8'h00;
      ext_data_oe_n <= 1'b1;
    end
    else
    begin
      ext_ale <= (state_reg == ST_IDLE && start_off && !bus_mux_select_bit) ||
                 (state_reg == ST_ALEH && cnt_reg != 4'h0);
      if (state_reg == ST_IDLE && start_off && !bus_mux_select_bit)
      begin
        ext_data_out  <= eff_addr[7:0];
        ext_data_oe_n <= 1'b0;
      end
      else if (state_reg == ST_SETUP && cnt_reg == 4'h0)
      begin
        ext_rd_n      <= wr_reg;
        ext_wr_n      <= !wr_reg;
        ext_data_out  <= wdata_reg;
        ext_data_oe_n <= !wr_reg;
      end
      else if (state_reg == ST_STRB && cnt_reg == 4'h0)
      begin
        ext_rd_n <= 1'b1;
        ext_wr_n <= 1'b1;
      end
      else if (state_reg == ST_HOLD && cnt_reg == 4'h0)
        ext_data_oe_n <= 1'b1;
      else if (state_reg == ST_ALEH && cnt_reg == 4'h0)
        ext_data_oe_n <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      move_done  <= 1'b0;
      move_rdata <= 8'h00;
    end
    else
    begin
      move_done <= ram_rd_pend || (state_reg == ST_TAIL && cnt_reg == 4'h1);
      if (ram_rd_pend)
        move_rdata <= ram_q;
      else if (state_reg == ST_STRB && cnt_reg == 4'h0 && !wr_reg && din_s2 == din_s3)
        // two agreeing samples; data must stand three cycles before strobe end
        move_rdata <= din_s2;
    end
  end

  assign move_busy = (state_reg != ST_IDLE) || ram_rd_pend;

  a_one_strobe_only: assert property (@(posedge ref_clk) disable iff (rst)
    !(!ext_rd_n && !ext_wr_n)) else $error("both strobes low");

  a_onchip_pins_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    (move_start && !move_busy && memory_mode_field == MODE_INTERNAL) |=> ext_rd_n && ext_wr_n && !ext_ale)
    else $error("pins moved on internal access");

  a_strobe_min_width: assert property (@(posedge ref_clk) disable iff (rst)
    ($fell(ext_rd_n) || $fell(ext_wr_n)) && strobe_width_field == 4'h0 |=> ext_rd_n && ext_wr_n)
    else $error("strobe width wrong");

  a_nonmux_no_latch: assert property (@(posedge ref_clk) disable iff (rst)
    bus_mux_select_bit && state_reg == ST_IDLE |=> !ext_ale) else $error("latch in non-mux");

  a_reset_timing: assert property (@(posedge ref_clk)
    $fell(rst) |-> timing_reg == TIMING_RESET) else $error("timing reset value");

  a_external_all_off: assert property (@(posedge ref_clk) disable iff (rst)
    (move_start && !move_busy && memory_mode_field == MODE_EXTERNAL) |=> state_reg != ST_IDLE)
    else $error("external mode stayed on-chip");

  sequence s_nonmux_min;
    (move_start && !move_busy && off_chip && bus_mux_select_bit && timing_reg == 8'h00) ##1 (state_reg != ST_IDLE) [*5];
  endsequence
  a_min_five_cycles: assert property (@(posedge ref_clk) disable iff (rst)
    s_nonmux_min |=> state_reg == ST_IDLE) else $error("off-chip move length wrong");

  a_upper_float: assert property (@(posedge ref_clk) disable iff (rst)
    (move_start && !move_busy && off_chip && !move_req.wide && memory_mode_field != MODE_BANK)
    |=> ext_addr_hi_oe_n && !ext_addr_lo_oe_n) else $error("upper lines driven");

  sequence s_ale_four_high;
    ext_ale [*4] ##1 !ext_ale;
  endsequence
  a_latch_width_max: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(ext_ale) && latch_width_field == 2'h3 |-> s_ale_four_high) else $error("latch pulse width wrong");

  a_latch_width_min: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(ext_ale) && latch_width_field == 2'h0 |=> !ext_ale) else $error("latch pulse width wrong");

  a_latch_addr_phase: assert property (@(posedge ref_clk) disable iff (rst)
    ext_ale |-> !ext_data_oe_n && ext_data_out == ext_addr[7:0]) else $error("address not on shared pins");

endmodule : xdata_if
`default_nettype wire

/* File: core/xdata_pkg.sv */
package xdata_pkg;

  // register indices on the plain register port
  localparam logic [7:0] TIMING_OFS      = 8'haa;
  localparam logic [7:0] CONFIG_OFS      = 8'ha0;
  localparam logic [7:0] PAGE_OFS        = 8'ha1;

  localparam logic [7:0] TIMING_RESET    = 8'hff;
  localparam logic [7:0] CONFIG_RESET    = 8'h00;
  localparam logic [7:0] PAGE_RESET      = 8'h00;

  // timing register fields
  localparam int SETUP_LSB  = 6;
  localparam int WIDTH_LSB  = 2;
  localparam int HOLD_LSB   = 0;
  // config register fields
  localparam int MUX_BIT    = 4;
  localparam int MODE_LSB   = 2;
  localparam int LATCH_LSB  = 0;

  localparam int RAM_AW     = 12;
  localparam logic [RAM_AW-1:0] RAM_WORDS_M1 = 12'hfff;

  localparam logic [1:0] MODE_INTERNAL = 2'h0;
  localparam logic [1:0] MODE_SPLIT    = 2'h1;
  localparam logic [1:0] MODE_BANK     = 2'h2;
  localparam logic [1:0] MODE_EXTERNAL = 2'h3;

  // tail cycles; setup, strobe and hold each add one more of the five fixed cycles
  localparam logic [1:0] FIXED_CYCLES  = 2'h2;

  typedef struct packed {
    logic        wide;
    logic        write;
    logic        index_sel;
    logic [7:0]  wdata;
  } move_req_s;

  typedef struct packed {
    logic [15:0] addr;
    logic        upper_en;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        rd_n;
    logic        wr_n;
    logic        ale;
    logic        data_oe_n;
  } ext_bus_s;

endpackage : xdata_pkg
